// [core/bce_pkg.sv]
package bce_pkg;

	localparam int unsigned BCE_ADDR_W  = 6;
	localparam int unsigned BCE_BYTES   = 16;

	// register map, one byte per address
	localparam logic [5:0] BCE_ADDR_CTRL       = 6'h00;
	localparam logic [5:0] BCE_ADDR_KEY_BASE   = 6'h10;
	localparam logic [5:0] BCE_ADDR_DATA_BASE  = 6'h20;
	localparam logic [5:0] BCE_ADDR_IRQ_STATUS = 6'h30;
	localparam logic [5:0] BCE_ADDR_IRQ_MASK   = 6'h31;
	localparam logic [5:0] BCE_ADDR_ENGINE     = 6'h32;
	localparam logic [1:0] BCE_BANK_MASK       = 2'h3;

	// control and interrupt bit positions
	localparam int unsigned BCE_CTRL_RUN    = 0;
	localparam int unsigned BCE_CTRL_ABORT  = 1;
	localparam int unsigned BCE_IRQ_DONE    = 0;
	localparam int unsigned BCE_IRQ_ABORTED = 1;

	localparam logic [7:0] BCE_REG_RESET   = 8'h00;
	localparam logic [3:0] BCE_LAST_ROUND  = 4'ha;
	localparam logic [3:0] BCE_FIRST_ROUND = 4'h1;
	localparam logic [7:0] BCE_RCON_INIT   = 8'h01;
	localparam logic [7:0] BCE_GF_POLY     = 8'h1b;
	localparam logic [7:0] BCE_SBOX_AFFINE = 8'h63;

	typedef enum logic [1:0] {
		BCE_IDLE  = 2'b00,
		BCE_RUN   = 2'b01,
		BCE_ABORT = 2'b10
	} bce_state_t;

	typedef struct packed {
		logic                  wr;
		logic                  rd;
		logic [BCE_ADDR_W-1:0] addr;
		logic [7:0]            wdata;
	} bce_bus_req_t;

	function automatic logic [7:0] bce_xtime(input logic [7:0] a);
		bce_xtime = {a[6:0], 1'b0} ^ (a[7] ? BCE_GF_POLY : 8'h00);
	endfunction

	function automatic logic [7:0] bce_gmul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] acc;
		logic [7:0] p;
		acc = 8'h00;
		p   = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) begin
				acc = acc ^ p;
			end
			p = bce_xtime(p);
		end
		bce_gmul = acc;
	endfunction

	// inverse as x^254 by an addition chain, then the affine map
	function automatic logic [7:0] bce_sbox(input logic [7:0] x);
		logic [7:0] x3;
		logic [7:0] x7;
		logic [7:0] x15;
		logic [7:0] x31;
		logic [7:0] x63;
		logic [7:0] x127;
		logic [7:0] inv;
		x3   = bce_gmul(bce_gmul(x, x), x);
		x7   = bce_gmul(bce_gmul(x3, x3), x);
		x15  = bce_gmul(bce_gmul(x7, x7), x);
		x31  = bce_gmul(bce_gmul(x15, x15), x);
		x63  = bce_gmul(bce_gmul(x31, x31), x);
		x127 = bce_gmul(bce_gmul(x63, x63), x);
		inv  = bce_gmul(x127, x127);
		bce_sbox = inv ^ {inv[6:0], inv[7]} ^ {inv[5:0], inv[7:6]}
			^ {inv[4:0], inv[7:5]} ^ {inv[3:0], inv[7:4]} ^ BCE_SBOX_AFFINE;
	endfunction

endpackage

// [core/bce_key_step.sv]
`timescale 1ns/1ps
module bce_key_step (
	input  wire logic [127:0] i_key,
	input  wire logic [7:0]   i_rcon,
	output logic      [127:0] o_key
);
	import bce_pkg::*;

	logic [31:0] w0;
	logic [31:0] w1;
	logic [31:0] w2;
	logic [31:0] w3;
	logic [31:0] t;
	logic [31:0] n0;
	logic [31:0] n1;
	logic [31:0] n2;

	assign {w0, w1, w2, w3} = i_key;

	// rotated, substituted last word with round constant
	assign t = {bce_sbox(w3[23:16]) ^ i_rcon, bce_sbox(w3[15:8]),
		bce_sbox(w3[7:0]), bce_sbox(w3[31:24])};

	assign n0    = w0 ^ t;
	assign n1    = w1 ^ n0;
	assign n2    = w2 ^ n1;
	assign o_key = {n0, n1, n2, w3 ^ n2};

endmodule

// [core/bce_round.sv]
`timescale 1ns/1ps
module bce_round (
	input  wire logic [127:0] i_state,
	input  wire logic [127:0] i_round_key,
	input  wire logic         i_last,
	output logic      [127:0] o_state
);
	import bce_pkg::*;

	logic [7:0] sub [16];
	logic [7:0] sh  [16];
	logic [7:0] mix [16];

	// byte j of the block sits at bits 127-8j downward
	for (genvar j = 0; j < 16; j++) begin : g_sub
		assign sub[j] = bce_sbox(i_state[127-8*j -: 8]);
	end

	for (genvar c = 0; c < 4; c++) begin : g_col
		for (genvar r = 0; r < 4; r++) begin : g_row
			assign sh[r+4*c] = sub[r+4*((c+r)%4)];
		end
		assign mix[4*c]   = bce_xtime(sh[4*c]) ^ bce_xtime(sh[4*c+1]) ^ sh[4*c+1]
			^ sh[4*c+2] ^ sh[4*c+3];
		assign mix[4*c+1] = sh[4*c] ^ bce_xtime(sh[4*c+1]) ^ bce_xtime(sh[4*c+2])
			^ sh[4*c+2] ^ sh[4*c+3];
		assign mix[4*c+2] = sh[4*c] ^ sh[4*c+1] ^ bce_xtime(sh[4*c+2])
			^ bce_xtime(sh[4*c+3]) ^ sh[4*c+3];
		assign mix[4*c+3] = bce_xtime(sh[4*c]) ^ sh[4*c] ^ sh[4*c+1] ^ sh[4*c+2]
			^ bce_xtime(sh[4*c+3]);
	end

	// the final round skips column mixing
	for (genvar j = 0; j < 16; j++) begin : g_out
		assign o_state[127-8*j -: 8] = (i_last ? sh[j] : mix[j]) ^ i_round_key[127-8*j -: 8];
	end

endmodule

// [core/bce_engine.sv]
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
module bce_engine (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_n,
	input  wire bce_pkg::bce_bus_req_t i_bus,
	output logic      [7:0]            o_rdata,
	output logic                       o_irq
);
	import bce_pkg::*;

	// control and status
	logic        run;
	logic        abort;
	logic [1:0]  irq_status;
	logic [1:0]  irq_mask;

	// byte storage
	logic [7:0]  key_mem  [BCE_BYTES];
	logic [7:0]  data_mem [BCE_BYTES];
	logic [127:0] key_vec;
	logic [127:0] data_vec;

	// engine
	bce_state_t  state;
	bce_state_t  next_state;
	logic [3:0]  round;
	logic [127:0] work;
	logic [127:0] round_key;
	logic [7:0]  rcon;
	logic [127:0] next_round_key;
	logic [127:0] next_work;
	logic [3:0]  next_round;
	logic [7:0]  next_rcon;

	// decoded bus strobes
	logic        wr_ctrl;
	logic        wr_mask;
	logic        wr_key;
	logic        wr_data;
	logic        rd_status;
	logic        rd_key;
	logic        rd_data;
	logic [7:0]  next_rdata;
	logic [3:0]  byte_idx;

	// engine events
	logic        start;
	logic        step;
	logic        finish;
	logic        abort_done;
	logic        enter_abort;
	logic        last_round;
	logic [1:0]  irq_event;

	function automatic logic in_bank(input logic [BCE_ADDR_W-1:0] addr,
		input logic [BCE_ADDR_W-1:0] base);
		in_bank = (addr[5:4] & BCE_BANK_MASK) == base[5:4];
	endfunction

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	assign byte_idx  = i_bus.addr[3:0];
	assign wr_ctrl   = i_bus.wr && (i_bus.addr == BCE_ADDR_CTRL);
	assign wr_mask   = i_bus.wr && (i_bus.addr == BCE_ADDR_IRQ_MASK);
	assign wr_key    = i_bus.wr && in_bank(i_bus.addr, BCE_ADDR_KEY_BASE);
	assign wr_data   = i_bus.wr && in_bank(i_bus.addr, BCE_ADDR_DATA_BASE);
	assign rd_status = i_bus.rd && (i_bus.addr == BCE_ADDR_IRQ_STATUS);
	assign rd_key    = i_bus.rd && in_bank(i_bus.addr, BCE_ADDR_KEY_BASE);
	assign rd_data   = i_bus.rd && in_bank(i_bus.addr, BCE_ADDR_DATA_BASE);

	// ---------------------------------------------------------------
	// packed views of the byte registers: index i carries bits 8i+7..8i
	// ---------------------------------------------------------------
	for (genvar i = 0; i < BCE_BYTES; i++) begin : g_vec
		assign key_vec[8*i +: 8]  = key_mem[i];
		assign data_vec[8*i +: 8] = data_mem[i];
	end

	// ---------------------------------------------------------------
	// engine sequencing
	// ---------------------------------------------------------------
	// abort from idle runs the same one-cycle sequence
	assign enter_abort = abort && (state != BCE_ABORT);
	assign start       = (state == BCE_IDLE) && run && !abort;
	assign step        = (state == BCE_RUN) && run && !abort;
	assign last_round  = (round == BCE_LAST_ROUND);
	assign finish      = step && last_round;
	assign abort_done  = (state == BCE_ABORT);
	assign next_round  = last_round ? '0 : round + BCE_FIRST_ROUND;
	assign next_rcon   = bce_xtime(rcon);

	always_comb begin
		next_state = state;
		case (state)
			BCE_IDLE: begin
				if (enter_abort) begin
					next_state = BCE_ABORT;
				end else if (start) begin
					next_state = BCE_RUN;
				end
			end
			BCE_RUN: begin
				if (enter_abort) begin
					next_state = BCE_ABORT;
				end else if (finish) begin
					next_state = BCE_IDLE;
				end
			end
			BCE_ABORT: begin
				// one cycle here, then back to idle
				next_state = BCE_IDLE;
			end
			default: begin
				next_state = BCE_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= BCE_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ---------------------------------------------------------------
	// round datapath; round keys are expanded on the fly, one per step
	// ---------------------------------------------------------------
	bce_key_step u_key_step (
		.i_key (round_key),
		.i_rcon(rcon),
		.o_key (next_round_key)
	);

	bce_round u_round (
		.i_state    (work),
		.i_round_key(next_round_key),
		.i_last     (last_round),
		.o_state    (next_work)
	);

	// working block and round key; held untouched while halted
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			work      <= '0;
			round_key <= '0;
			rcon      <= BCE_RCON_INIT;
			round     <= '0;
		end else if (start) begin
			work      <= data_vec ^ key_vec;
			round_key <= key_vec;
			rcon      <= BCE_RCON_INIT;
			round     <= BCE_FIRST_ROUND;
		end else if (step) begin
			work      <= next_work;
			round_key <= next_round_key;
			rcon      <= next_rcon;
			round     <= next_round;
		end else if (abort_done) begin
			round     <= '0;
		end
	end

	// ---------------------------------------------------------------
	// control register
	// ---------------------------------------------------------------
	// a software write beats a hardware clear in the same cycle
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			run <= 1'b0;
		end else if (wr_ctrl) begin
			run <= i_bus.wdata[BCE_CTRL_RUN];
		// abort drops run too, or the idle engine would restart at once
		end else if (finish || abort_done) begin
			run <= 1'b0;
		end
	end

	// abort stays set until its one-cycle sequence has run
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			abort <= 1'b0;
		end else if (wr_ctrl) begin
			abort <= i_bus.wdata[BCE_CTRL_ABORT];
		end else if (abort_done) begin
			abort <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// key bytes
	// sampled only at start: a change mid-run applies to the next run
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < BCE_BYTES; i++) begin
				key_mem[i] <= BCE_REG_RESET;
			end
		end else if (wr_key) begin
			key_mem[byte_idx] <= i_bus.wdata;
		end
	end

	// ---------------------------------------------------------------
	// data bytes; the ciphertext write-back takes precedence
	// over a software byte write in the finishing cycle, which is lost
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < BCE_BYTES; i++) begin
				data_mem[i] <= BCE_REG_RESET;
			end
		end else if (finish) begin
			for (int i = 0; i < BCE_BYTES; i++) begin
				data_mem[i] <= next_work[8*i +: 8];
			end
		end else if (wr_data) begin
			data_mem[byte_idx] <= i_bus.wdata;
		end
	end

	// ---------------------------------------------------------------
	// interrupts: sticky, cleared by reading, new events win
	// ---------------------------------------------------------------
	assign irq_event[BCE_IRQ_DONE]    = finish;
	assign irq_event[BCE_IRQ_ABORTED] = abort_done;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_status <= '0;
		end else if (rd_status) begin
			// an event in the clearing cycle survives the read
			irq_status <= irq_event;
		end else begin
			irq_status <= irq_status | irq_event;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_mask <= '0;
		end else if (wr_mask) begin
			irq_mask <= i_bus.wdata[1:0];
		end
	end

	// level output, drops as soon as a status read clears the bits
	assign o_irq = |(irq_status & irq_mask);

	// ---------------------------------------------------------------
	// read data, one cycle after the read strobe and only then
	// ---------------------------------------------------------------
	always_comb begin
		next_rdata = BCE_REG_RESET;
		if (rd_key) begin
			next_rdata = key_mem[byte_idx];
		end else if (rd_data) begin
			next_rdata = data_mem[byte_idx];
		end else if (i_bus.rd) begin
			case (i_bus.addr)
				BCE_ADDR_CTRL: begin
					next_rdata = {6'h00, abort, run};
				end
				BCE_ADDR_IRQ_STATUS: begin
					next_rdata = {6'h00, irq_status};
				end
				BCE_ADDR_IRQ_MASK: begin
					next_rdata = {6'h00, irq_mask};
				end
				BCE_ADDR_ENGINE: begin
					next_rdata = {2'h0, state, round};
				end
				default: begin
					next_rdata = BCE_REG_RESET;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// zero outside the cycle that follows a read
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= BCE_REG_RESET;
		end else begin
			o_rdata <= next_rdata;
		end
	end

endmodule

// [tb/bce_engine_assertions.sv]
`timescale 1ns/1ps
module bce_engine_checker (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_n,
	input  wire bce_pkg::bce_bus_req_t i_bus,
	input  wire logic      [7:0]       o_rdata,
	input  wire logic                  o_irq
);
	import bce_pkg::*;
	logic [3:0] run_age;
	logic [1:0] mask_copy;
	logic       ctrl_wr;
	logic       ctrl_rd;
	logic       idle;
	assign ctrl_wr = i_bus.wr && (i_bus.addr == BCE_ADDR_CTRL);
	assign ctrl_rd = i_bus.rd && (i_bus.addr == BCE_ADDR_CTRL);
	assign idle    = (run_age == 4'h0) || (run_age == 4'hf);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// cycles since a plain start; saturates so a long quiet spell counts as finished
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			run_age <= 4'h0;
		end else if (ctrl_wr) begin
			run_age <= (i_bus.wdata[1:0] == 2'b01) ? 4'h1 : 4'h0;
		end else if (!idle) begin
			run_age <= run_age + 4'h1;
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mask_copy <= 2'b00;
		end else if (i_bus.wr && (i_bus.addr == BCE_ADDR_IRQ_MASK)) begin
			mask_copy <= i_bus.wdata[1:0];
		end
	end
	a_rdata_idle: assert property (!i_bus.rd |=> o_rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (i_bus.rd && (i_bus.addr > BCE_ADDR_ENGINE
		|| (i_bus.addr[5:4] == 2'b00 && i_bus.addr != 6'h00)) |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_ctrl_upper: assert property (ctrl_rd |=> o_rdata[7:2] == 6'h00)
		else $error("control upper bits not zero");
	a_engine_upper: assert property (i_bus.rd && i_bus.addr == BCE_ADDR_ENGINE
		|=> o_rdata[7:6] == 2'b00) else $error("engine upper bits not zero");
	a_key_readback: assert property (
		i_bus.wr && i_bus.addr[5:4] == 2'b01 ##1 !i_bus.wr
		##1 (i_bus.rd && i_bus.addr == $past(i_bus.addr, 2))
		|=> o_rdata == $past(i_bus.wdata, 3)) else $error("key byte readback wrong");
	a_data_readback: assert property (
		i_bus.wr && i_bus.addr[5:4] == 2'b10 && idle ##1 !i_bus.wr
		##1 (i_bus.rd && i_bus.addr == $past(i_bus.addr, 2))
		|=> o_rdata == $past(i_bus.wdata, 3)) else $error("data byte readback wrong");
	a_abort_done: assert property (
		ctrl_wr && i_bus.wdata[1] ##1 (!i_bus.wr) [*2] ##1 ctrl_rd
		|=> o_rdata[1:0] == 2'b00) else $error("abort bits not cleared");
	a_run_clears: assert property (ctrl_rd && run_age >= 4'hc |=> !o_rdata[0])
		else $error("run bit still set after a full run");
	a_irq_masked: assert property (mask_copy == 2'b00 |-> !o_irq)
		else $error("interrupt high while fully masked");
	c_start: cover property (ctrl_wr && i_bus.wdata == 8'h01);
	c_finish: cover property (ctrl_rd && run_age >= 4'hc);
	c_irq: cover property ($rose(o_irq));
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	import bce_pkg::*;
	localparam logic [127:0] KEY = 128'h000102030405060708090a0b0c0d0e0f;
	localparam logic [127:0] PT  = 128'h00112233445566778899aabbccddeeff;
	localparam logic [127:0] CT  = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
	logic         i_clk;
	logic         i_rst_n;
	bce_bus_req_t bus;
	logic [7:0]   rdata;
	logic         irq;
	int           n_fail;
	int           tests_run;
	bce_engine DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus), .o_rdata(rdata), .o_irq(irq));
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
		@(posedge i_clk);
		bus <= {1'b1, 1'b0, a, d};
		@(posedge i_clk);
		bus <= '0;
	endtask
	task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
		@(posedge i_clk);
		bus <= {1'b0, 1'b1, a, 8'h00};
		@(posedge i_clk);
		bus <= '0;
		#1 d = rdata;
	endtask
	task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(a, d);
		check(d, exp);
	endtask
	// byte n of a block sits at base+n and carries bits 8n+7..8n
	task automatic blk(input logic [5:0] base, input logic [127:0] v, input bit wen);
		for (int i = 0; i < 16; i++) begin
			if (wen) wr_reg(base + 6'(i), v[8*i +: 8]);
			rd_chk(base + 6'(i), v[8*i +: 8]);
		end
	endtask
	task automatic wait_done();
		logic [7:0] d;
		d = 8'h01;
		for (int i = 0; i < 40 && d[0] !== 1'b0; i++) rd_reg(BCE_ADDR_CTRL, d);
		check(d, 8'h00);
	endtask
	task automatic t_reset();
		logic [5:0] al [10];
		al = '{BCE_ADDR_CTRL, BCE_ADDR_KEY_BASE, 6'h1f, BCE_ADDR_DATA_BASE, 6'h2f,
			BCE_ADDR_IRQ_STATUS, BCE_ADDR_IRQ_MASK, BCE_ADDR_ENGINE, 6'h05, 6'h3f};
		for (int i = 0; i < 10; i++) rd_chk(al[i], 8'h00);
	endtask
	task automatic t_regs();
		blk(BCE_ADDR_KEY_BASE, KEY, 1'b1);
		blk(BCE_ADDR_DATA_BASE, PT, 1'b1);
	endtask
	task automatic t_encrypt();
		wr_reg(BCE_ADDR_IRQ_MASK, 8'h03);
		wr_reg(BCE_ADDR_CTRL, 8'h01);
		rd_chk(BCE_ADDR_CTRL, 8'h01);
		wait_done();
		check({7'h00, irq}, 8'h01);
		rd_chk(BCE_ADDR_IRQ_STATUS, 8'h01);
		check({7'h00, irq}, 8'h00);
		blk(BCE_ADDR_DATA_BASE, CT, 1'b0);
	endtask
	task automatic t_halt();
		blk(BCE_ADDR_DATA_BASE, PT, 1'b1);
		wr_reg(BCE_ADDR_CTRL, 8'h01);
		wr_reg(BCE_ADDR_CTRL, 8'h00);
		repeat (20) @(posedge i_clk);
		rd_chk(BCE_ADDR_CTRL, 8'h00);
		rd_chk(BCE_ADDR_ENGINE, {2'h0, BCE_RUN, 4'h2});
		rd_chk(BCE_ADDR_IRQ_STATUS, 8'h00);
		blk(BCE_ADDR_DATA_BASE, PT, 1'b0);
		wr_reg(BCE_ADDR_CTRL, 8'h01);
		wait_done();
		blk(BCE_ADDR_DATA_BASE, CT, 1'b0);
	endtask
	task automatic t_abort();
		wr_reg(BCE_ADDR_IRQ_MASK, 8'h00);
		#1 check({7'h00, irq}, 8'h00);
		rd_chk(BCE_ADDR_IRQ_STATUS, 8'h01);
		blk(BCE_ADDR_DATA_BASE, PT, 1'b1);
		wr_reg(BCE_ADDR_CTRL, 8'h01);
		wr_reg(BCE_ADDR_CTRL, 8'h02);
		@(posedge i_clk);
		rd_chk(BCE_ADDR_CTRL, 8'h00);
		wr_reg(BCE_ADDR_IRQ_MASK, 8'h02);
		#1 check({7'h00, irq}, 8'h01);
		rd_chk(BCE_ADDR_IRQ_STATUS, 8'h02);
		check({7'h00, irq}, 8'h00);
		blk(BCE_ADDR_DATA_BASE, PT, 1'b0);
	endtask
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	initial begin
		repeat (20000) @(posedge i_clk);
		n_fail++;
		tally_and_finish();
	end
	initial begin
		i_rst_n = 1'b0;
		bus = '0;
		n_fail = 0;
		tests_run = 0;
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		t_reset();
		t_regs();
		t_encrypt();
		t_halt();
		t_abort();
		tally_and_finish();
	end
endmodule
bind bce_engine bce_engine_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(i_bus),
	.o_rdata(o_rdata), .o_irq(o_irq));
